// ===== hw/ctd_pkg.sv
// Constants, field layouts and carrier types for the core tick down-counter.
// Assumes a single processor clock and a plain one-cycle register port.
//
// Overview of operation
// - Reload field bits 23:0 feed the counter
// - Flag and request only on one-to-zero step
// - Current count reads live in bits 23:0
// - Writing current count zeroes it and flag
// - Calibration bit 31 reads as one
// - Calibration bit 30 reads as one
// - Calibration bits 23:0 read zero, 29:24 reserved
// - Counter stops while processor clock gated
// - Reload and count need no reset value
// - Registers decode at base plus 0x00..0x0C
// - Count down, reload after zero, keep counting
// - Flag set at zero, cleared by control read
// - Exception enable bit 1 gates the request
// - Counter holds while processor halted for debug
package ctd_pkg;

  // Block base address, register word offsets and block mask
  localparam logic [31:0] CTD_BASE_ADDR      = 32'hE000E010;
  localparam logic [3:0]  CTD_OFS_CTRL       = 4'h0;
  localparam logic [3:0]  CTD_OFS_RELOAD     = 4'h4;
  localparam logic [3:0]  CTD_OFS_CURRENT    = 4'h8;
  localparam logic [3:0]  CTD_OFS_CALIB      = 4'hC;
  localparam logic [27:0] CTD_BLOCK_MASK     = 28'hFFFFFFF;

  // Counter geometry
  localparam int          CTD_COUNT_W        = 24;

  // Control and status field positions
  localparam int          CTD_CSR_ENABLE_BIT = 0;
  localparam int          CTD_CSR_EXC_BIT    = 1;
  localparam int          CTD_CSR_CLKSEL_BIT = 2;
  localparam int          CTD_CSR_FLAG_BIT   = 16;

  // Reset values
  localparam logic [2:0]  CTD_CSR_CTRL_RESET = 3'h4;
  localparam logic [23:0] CTD_COUNT_RESET    = 24'h000000;

  // Calibration word fields
  localparam int          CTD_CAL_NO_REF_CLK_BIT = 31;
  localparam int          CTD_CAL_INEXACT_BIT    = 30;
  localparam logic [23:0] CTD_CAL_TEN_MS_COUNT   = 24'h000000;

  // Software-written control bits
  typedef struct packed {
    logic tick_clock_select;
    logic zero_exception_enable;
    logic count_enable;
  } ctd_ctrl_type;

  // One register port request
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } ctd_bus_req_type;

  // Which register a request selects
  typedef enum logic [2:0] {
    CTD_SEL_NONE    = 3'b000,
    CTD_SEL_CTRL    = 3'b001,
    CTD_SEL_RELOAD  = 3'b010,
    CTD_SEL_CURRENT = 3'b011,
    CTD_SEL_CALIB   = 3'b100
  } ctd_sel_type;

endpackage

// ===== hw/ctd_down_counter.sv
// Loadable down-counter with a one-to-zero step marker.
// Assumes load, clear and step come from logic on the same clock.
`timescale 1ns/1ps

module ctd_down_counter #(
  parameter int W = 24
) (
  // Clock and reset
  input  wire logic         i_sys_clk,
  input  wire logic         i_rst_n,
  // Controls
  input  wire logic         i_clear,
  input  wire logic         i_step,
  input  wire logic [W-1:0] i_reload,
  // Status
  output logic      [W-1:0] o_count,
  output logic              o_hit_zero
);

  logic [W-1:0] count_q;
  logic [W-1:0] count_d;
  logic         is_zero;
  logic         is_one;

  assign is_zero = (count_q == '0);
  assign is_one  = (count_q == W'(1));

  // Zero reloads on the next step, others count down; clear overrides all
  always_comb begin
    count_d = count_q;
    if (i_clear) begin
      count_d = '0;
    end else if (i_step) begin
      if (is_zero) begin
        count_d = i_reload;
      end else begin
        count_d = count_q - W'(1);
      end
    end
  end

  // Only a real step from one marks zero, so a zero reload stays silent
  assign o_hit_zero = i_step && is_one;

  // Reset to zero although software must not rely on it
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

  assign o_count = count_q;

endmodule

// ===== hw/ctd_tick_timer.sv
// Core tick down-counter: register port, control state and read-back.
// Assumes halt and gating inputs come from core logic on the same clock.
`timescale 1ns/1ps

module ctd_tick_timer #(
  parameter logic [31:0] BASE_ADDR = ctd_pkg::CTD_BASE_ADDR,
  parameter int          COUNT_W   = ctd_pkg::CTD_COUNT_W
) (
  // Clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  // Register port
  input  wire logic [31:0] i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  output logic             o_access_fault,
  // Core status
  input  wire logic        i_clk_gated,
  input  wire logic        i_debug_halt,
  // Exception request and zero event marker
  output logic             o_tick_req,
  output logic             o_count_zero
);

  // Request bundle
  ctd_pkg::ctd_bus_req_type req;

  assign req.addr  = i_addr;
  assign req.wdata = i_wdata;
  assign req.wr    = i_wr;
  assign req.rd    = i_rd;

  // Address decode
  logic                 in_block;
  logic                 aligned;
  logic [3:0]           word_ofs;
  logic                 any_access;
  ctd_pkg::ctd_sel_type sel;

  assign any_access = req.wr || req.rd;
  assign in_block   = (req.addr[31:4] == BASE_ADDR[31:4]);
  assign word_ofs   = req.addr[3:0];
  // Misaligned accesses are ignored rather than half-decoded
  assign aligned    = (req.addr[1:0] == 2'h0);

  assign sel = !(in_block && aligned)                  ? ctd_pkg::CTD_SEL_NONE :
               (word_ofs == ctd_pkg::CTD_OFS_CTRL)     ? ctd_pkg::CTD_SEL_CTRL :
               (word_ofs == ctd_pkg::CTD_OFS_RELOAD)   ? ctd_pkg::CTD_SEL_RELOAD :
               (word_ofs == ctd_pkg::CTD_OFS_CURRENT)  ? ctd_pkg::CTD_SEL_CURRENT :
                                                         ctd_pkg::CTD_SEL_CALIB;

  // Strobes per register
  logic wr_ctrl;
  logic wr_reload;
  logic wr_current;
  logic rd_ctrl;
  logic rd_hit;

  assign wr_ctrl    = req.wr && (sel == ctd_pkg::CTD_SEL_CTRL);
  assign wr_reload  = req.wr && (sel == ctd_pkg::CTD_SEL_RELOAD);
  assign wr_current = req.wr && (sel == ctd_pkg::CTD_SEL_CURRENT);
  assign rd_ctrl    = req.rd && (sel == ctd_pkg::CTD_SEL_CTRL);
  assign rd_hit     = req.rd && (sel != ctd_pkg::CTD_SEL_NONE);

  // A block-local access that is not word aligned is reported, not performed
  logic fault_d;

  assign fault_d = any_access && in_block && !aligned;

  // Control register
  ctd_pkg::ctd_ctrl_type ctrl_q;
  ctd_pkg::ctd_ctrl_type ctrl_d;

  assign ctrl_d.count_enable          = wr_ctrl ? req.wdata[ctd_pkg::CTD_CSR_ENABLE_BIT] :
                                                  ctrl_q.count_enable;
  assign ctrl_d.zero_exception_enable = wr_ctrl ? req.wdata[ctd_pkg::CTD_CSR_EXC_BIT] :
                                                  ctrl_q.zero_exception_enable;
  // Only the processor clock exists; the select bit is kept for software only
  assign ctrl_d.tick_clock_select     = wr_ctrl ? req.wdata[ctd_pkg::CTD_CSR_CLKSEL_BIT] :
                                                  ctrl_q.tick_clock_select;

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      ctrl_q <= ctd_pkg::CTD_CSR_CTRL_RESET;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // Reload register
  logic [COUNT_W-1:0] reload_q;
  logic [COUNT_W-1:0] reload_d;

  assign reload_d = wr_reload ? req.wdata[COUNT_W-1:0] : reload_q;

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      reload_q <= ctd_pkg::CTD_COUNT_RESET;
    end else begin
      reload_q <= reload_d;
    end
  end

  // Counting gate: enabled, clock running, core not halted
  logic               count_step;
  logic [COUNT_W-1:0] count_val;
  logic               hit_zero;

  assign count_step = ctrl_q.count_enable && !i_clk_gated && !i_debug_halt;

  ctd_down_counter #(
    .W          (COUNT_W)
  ) u_counter (
    .i_sys_clk  (i_sys_clk),
    .i_rst_n    (i_rst_n),
    .i_clear    (wr_current),
    .i_step     (count_step),
    .i_reload   (reload_q),
    .o_count    (count_val),
    .o_hit_zero (hit_zero)
  );

  // Sticky flag: a zero step in the same cycle wins over a control read clear, but a count write wins over the zero step
  logic flag_q;
  logic flag_d;
  logic flag_set;
  logic flag_clr;

  assign flag_set = hit_zero && !wr_current;
  assign flag_clr = rd_ctrl || wr_current;
  assign flag_d   = flag_set ? 1'b1 :
                    flag_clr ? 1'b0 :
                               flag_q;

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  // Exception request: one-cycle pulse; a count write suppresses it
  logic tick_req_q;
  logic tick_req_d;

  assign tick_req_d = hit_zero && ctrl_q.zero_exception_enable && !wr_current;

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      tick_req_q <= 1'b0;
    end else begin
      tick_req_q <= tick_req_d;
    end
  end

  // Zero event marker for the core, independent of the exception enable bit
  logic zero_evt_q;

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      zero_evt_q <= 1'b0;
    end else begin
      zero_evt_q <= flag_set;
    end
  end

  // Read words
  logic [31:0] csr_word;
  logic [31:0] reload_word;
  logic [31:0] current_word;
  logic [31:0] calib_word;

  always_comb begin
    csr_word                                = 32'h00000000;
    csr_word[ctd_pkg::CTD_CSR_ENABLE_BIT]   = ctrl_q.count_enable;
    csr_word[ctd_pkg::CTD_CSR_EXC_BIT]      = ctrl_q.zero_exception_enable;
    csr_word[ctd_pkg::CTD_CSR_CLKSEL_BIT]   = ctrl_q.tick_clock_select;
    // Flag shows its value before the clear this read causes
    csr_word[ctd_pkg::CTD_CSR_FLAG_BIT]     = flag_q;
  end

  assign reload_word  = {{(32 - COUNT_W){1'b0}}, reload_q};
  assign current_word = {{(32 - COUNT_W){1'b0}}, count_val};

  always_comb begin
    calib_word                                 = 32'h00000000;
    calib_word[ctd_pkg::CTD_CAL_NO_REF_CLK_BIT] = 1'b1;
    calib_word[ctd_pkg::CTD_CAL_INEXACT_BIT]    = 1'b1;
    calib_word[23:0]                            = ctd_pkg::CTD_CAL_TEN_MS_COUNT;
  end

  // Read select; unmapped or misaligned reads return zero
  logic [31:0] rdata_sel;

  assign rdata_sel = !rd_hit                             ? 32'h00000000 :
                     (sel == ctd_pkg::CTD_SEL_CTRL)      ? csr_word :
                     (sel == ctd_pkg::CTD_SEL_RELOAD)    ? reload_word :
                     (sel == ctd_pkg::CTD_SEL_CURRENT)   ? current_word :
                                                           calib_word;

  // Read data stand only in the cycle after the strobe
  logic [31:0] rdata_q;
  logic        fault_q;

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      rdata_q <= 32'h00000000;
      fault_q <= 1'b0;
    end else begin
      rdata_q <= rdata_sel;
      fault_q <= fault_d;
    end
  end

  // Outputs
  assign o_rdata        = rdata_q;
  assign o_access_fault = fault_q;
  assign o_tick_req     = tick_req_q;
  assign o_count_zero   = zero_evt_q;

endmodule

// ===== dv/ctd_tick_timer_asserts.sv
// Port checker for the tick down-counter.
// Assumes it is bound into ctd_tick_timer on the one processor clock.
`timescale 1ns/1ps

module ctd_tick_timer_asserts #(
  parameter logic [31:0] BASE_ADDR = ctd_pkg::CTD_BASE_ADDR,
  parameter int          COUNT_W   = ctd_pkg::CTD_COUNT_W
) (
  // Clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  // Register port
  input  wire logic [31:0] i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  input  wire logic [31:0] o_rdata,
  input  wire logic        o_access_fault,
  // Core status and request
  input  wire logic        i_clk_gated,
  input  wire logic        i_debug_halt,
  input  wire logic        o_tick_req,
  input  wire logic        o_count_zero
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  wire       in_blk = i_addr[31:4] == BASE_ADDR[31:4];
  wire [3:0] ofs    = i_addr[3:0];
  wire       wr_cur = i_wr && in_blk && ofs == 4'h8;

  AST_RD_IDLE: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("Read data not zero outside read answer");
  AST_OUTSIDE: assert property ($past(i_rd && !in_blk) |-> o_rdata == 32'h0)
    else $error("Read outside block returned data");
  AST_CALIB: assert property ($past(i_rd && in_blk && ofs == 4'hC) |-> o_rdata == 32'hC0000000)
    else $error("Calibration word read wrong");
  AST_CUR_RSV: assert property ($past(i_rd && in_blk && ofs == 4'h8) |-> o_rdata[31:COUNT_W] == '0)
    else $error("Current count upper bits not zero");
  AST_CSR_RSV: assert property ($past(i_rd && in_blk && ofs == 4'h0) |-> (o_rdata & 32'hFFFEFFF8) == 32'h0)
    else $error("Control word reserved bits set");
  AST_FAULT: assert property ((i_wr || i_rd) && in_blk && i_addr[1:0] != 2'h0 |=> o_access_fault)
    else $error("Misaligned access gave no fault");
  AST_REQ_GATE: assert property (o_tick_req |-> o_count_zero)
    else $error("Request without a zero step");
  AST_PULSE: assert property (o_count_zero |=> !o_count_zero)
    else $error("Zero pulse longer than one cycle");
  AST_GATED: assert property (i_clk_gated [*2] |=> !o_count_zero)
    else $error("Counter stepped while clock gated");
  AST_HALT: assert property (i_debug_halt [*2] |=> !o_count_zero)
    else $error("Counter stepped while halted");
  AST_CUR_WR: assert property (wr_cur |-> ##1 !o_tick_req && !o_count_zero)
    else $error("Count write raised a request");
endmodule

bind ctd_tick_timer ctd_tick_timer_asserts #(.BASE_ADDR(BASE_ADDR), .COUNT_W(COUNT_W)) u_chk (
  .i_sys_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_access_fault,
  .i_clk_gated, .i_debug_halt, .o_tick_req, .o_count_zero
);

// ===== dv/ctd_tick_timer_bench.sv
// Self-checking bench for the tick down-counter register port.
// Assumes the package, design and checker are compiled before it.
`timescale 1ns/1ps

module ctd_tick_timer_bench;
  localparam logic [31:0] B = ctd_pkg::CTD_BASE_ADDR;
  logic        i_sys_clk    = 1'b0;
  logic        i_rst_n      = 1'b0;
  logic [31:0] i_addr       = 32'h0;
  logic [31:0] i_wdata      = 32'h0;
  logic        i_wr         = 1'b0;
  logic        i_rd         = 1'b0;
  logic        i_clk_gated  = 1'b0;
  logic        i_debug_halt = 1'b0;
  logic [31:0] o_rdata;
  logic        o_access_fault;
  logic        o_tick_req;
  logic        o_count_zero;
  logic        flt;
  int          err_total = 0;
  int          checked   = 0;
  int          cyc       = 0;
  int          n;

  ctd_tick_timer dut (
    .i_sys_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_access_fault,
    .i_clk_gated, .i_debug_halt, .o_tick_req, .o_count_zero
  );

  initial forever #12.5 i_sys_clk = ~i_sys_clk;

  // Whole run needs under two hundred cycles, so this only trips on a hang
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      report_and_stop();
    end
  end

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_sys_clk);
    i_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e, input string nm);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_sys_clk);
    i_rd   <= 1'b0;
    #1;
    chk(nm, o_rdata, e);
    flt = o_access_fault;
  endtask

  // Bounded wait for the next zero pulse; k returns the cycles waited
  task automatic wait_zero(output int k);
    k = 0;
    do begin
      @(posedge i_sys_clk);
      #1;
      k++;
    end while (o_count_zero !== 1'b1 && k < 200);
    if (o_count_zero !== 1'b1) err_total++;
  endtask

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    rd(B, 32'h4, "ctrl_reset");
    rd(B + 32'hC, 32'hC0000000, "calib");
    wr(B + 32'hC, 32'h0);
    rd(B + 32'hC, 32'hC0000000, "calib_ro");
    rd(B + 32'h10, 32'h0, "outside");
    chk("outside_fault", {31'h0, flt}, 32'h0);
    rd(B + 32'h6, 32'h0, "misaligned");
    chk("fault", {31'h0, flt}, 32'h1);
    wr(B + 32'h4, 32'hFFFFFFFF);
    rd(B + 32'h4, 32'h00FFFFFF, "reload");
    wr(B + 32'h4, 32'h9);
    wr(B + 32'h8, 32'h5);
    rd(B + 32'h8, 32'h0, "count_clear");
    i_debug_halt <= 1'b1;
    // Processor clock selected, as it is the only source
    wr(B, 32'h7);
    rd(B + 32'h8, 32'h0, "halted");
    @(posedge i_sys_clk);
    i_debug_halt <= 1'b0;
    rd(B + 32'h8, 32'h9, "first_load");
    @(posedge i_sys_clk);
    i_clk_gated <= 1'b1;
    rd(B + 32'h8, 32'h7, "gated");
    i_clk_gated <= 1'b0;
    wait_zero(n);
    chk("req_on", {31'h0, o_tick_req}, 32'h1);
    rd(B, 32'h10007, "flag_set");
    rd(B, 32'h7, "flag_read_clear");
    wait_zero(n);
    wait_zero(n);
    chk("period", 32'(n), 32'hA);
    // Count reloads 9 next; the write lands on the edge that steps 1 to 0
    repeat (8) @(posedge i_sys_clk);
    wr(B + 32'h8, 32'h0);
    #1;
    chk("wr_race_req", {31'h0, o_tick_req}, 32'h0);
    chk("wr_race_zero", {31'h0, o_count_zero}, 32'h0);
    rd(B, 32'h7, "wr_race_flag");
    wr(B, 32'h5);
    wait_zero(n);
    chk("req_off", {31'h0, o_tick_req}, 32'h0);
    // Zero reload only idles once the count is cleared as well
    wr(B + 32'h4, 32'h0);
    wr(B + 32'h8, 32'h0);
    rd(B, 32'h5, "flag_write_clear");
    n = 0;
    repeat (40) begin
      @(posedge i_sys_clk);
      #1;
      if (o_count_zero === 1'b1) n++;
    end
    chk("zero_reload", 32'(n), 32'h0);
    report_and_stop();
  end
endmodule
